// >>> hw/sap_alarm_regs.sv
// Purpose: Threshold, alarm enable and lane polarity register bank.
// Assumes: Measurement codes and error levels come from logic on this clock.
// Notes:   Lane samples are pin levels and are synchronised before use.
`timescale 1ns/10ps
`default_nettype none
module sap_alarm_regs (
  input  wire logic                            i_ref_clk,
  input  wire logic                            i_reset_n,
  input  wire sap_pkg::sap_bus_t               i_bus,
  output logic [sap_pkg::DATA_W-1:0]           o_rd_data,
  input  wire sap_pkg::sap_meas_t              i_meas,
  input  wire logic [sap_pkg::RX_W-1:0]        i_rx_err,
  input  wire logic [sap_pkg::RET_W-1:0]       i_ret_err,
  input  wire logic [sap_pkg::NLANE-1:0]       i_hs_lane,
  input  wire logic [sap_pkg::NLANE-1:0]       i_lp_lane,
  output logic [sap_pkg::NLANE-1:0]            o_hs_lane,
  output logic [sap_pkg::NLANE-1:0]            o_lp_lane,
  output logic [sap_pkg::RX_W-1:0]             o_rx_alarm,
  output logic [2*sap_pkg::NMON-1:0]           o_mon_alarm,
  output logic [sap_pkg::RET_W-1:0]            o_ret_alarm,
  output logic                                 o_irq
);
  localparam int unsigned NM = sap_pkg::NMON;
  localparam int unsigned LW = sap_pkg::LIM_W;

  logic [7:0]              lim_q [NM];
  logic [7:0]              ctrl_q;
  logic [7:0]              rx_mask_q;
  logic [7:0]              mon_mask_q;
  logic [7:0]              ret_mask_q;
  logic [sap_pkg::NLANE-1:0] hs_pol_q;
  logic [7:0]              lp_pol_q;
  logic [sap_pkg::HS_DBG_W-1:0] hs_dbg_q;
  logic [sap_pkg::HS_DBG_W-1:0] lp_dbg_q;
  logic [2*NM-1:0]         mon_stat_q;
  logic [sap_pkg::IRQ_W-1:0] irq_stat_q;
  logic [sap_pkg::IRQ_W-1:0] irq_mask_q;
  logic [sap_pkg::NLANE-1:0] hs_s1_q;
  logic [sap_pkg::NLANE-1:0] hs_s2_q;
  logic [sap_pkg::NLANE-1:0] lp_s1_q;
  logic [sap_pkg::NLANE-1:0] lp_s2_q;
  logic [2*NM-1:0]         cond;
  logic [NM-1:0]           mon_on;
  logic [LW-1:0]           meas [NM];
  logic [sap_pkg::RX_W-1:0]  rx_gate;
  logic [2*NM-1:0]         mon_gate;
  logic [sap_pkg::RET_W-1:0] ret_gate;
  logic [sap_pkg::IRQ_W-1:0] irq_ev;
  logic [7:0]              rd_d;
  logic                    stat_clr;

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = i_bus.wr && (i_bus.addr == a);
  endfunction

  assign meas[0] = i_meas.mon0;
  assign meas[1] = i_meas.mon1;
  assign meas[2] = i_meas.temp;

  // Monitor activity: voltage select field and the temperature enable.
  assign mon_on[0] = ctrl_q[sap_pkg::CTRL_SEL_LSB];
  assign mon_on[1] = ctrl_q[sap_pkg::CTRL_SEL_LSB+1];
  assign mon_on[2] = ctrl_q[sap_pkg::CTRL_TEN_LSB+:2] ==
                     sap_pkg::CTRL_TEN_ON;

  // One comparator pair per monitor; cond bit 2i+1 is high, 2i is low.
  // An equal code raises neither side, so a code on the limit is quiet.
  for (genvar gi = 0; gi < NM; gi++) begin : g_mon
    assign cond[2*gi+1] = mon_on[gi] &&
      (meas[gi] > lim_q[gi][sap_pkg::LIM_HI_LSB+:LW]);
    assign cond[2*gi]   = mon_on[gi] &&
      (meas[gi] < lim_q[gi][sap_pkg::LIM_LO_LSB+:LW]);
  end

  assign rx_gate  = i_rx_err & rx_mask_q[sap_pkg::RX_W-1:0];
  assign mon_gate = cond & mon_mask_q[2*NM-1:0];
  assign ret_gate = i_ret_err & ret_mask_q[sap_pkg::RET_W-1:0];
  assign irq_ev[sap_pkg::IRQ_RX]  = |rx_gate;
  assign irq_ev[sap_pkg::IRQ_MON] = |mon_gate;
  assign irq_ev[sap_pkg::IRQ_RET] = |ret_gate;

  // A named strobe lets the checks look back at the clear request.
  assign stat_clr = wr_at(sap_pkg::ADR_MON_STAT);

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      for (int i = 0; i < NM; i++) begin
        lim_q[i] <= sap_pkg::RST_LIM;
      end
    end else begin
      if (wr_at(sap_pkg::ADR_MON0_LIM)) begin
        lim_q[0] <= i_bus.wdata;
      end
      if (wr_at(sap_pkg::ADR_MON1_LIM)) begin
        lim_q[1] <= i_bus.wdata;
      end
      if (wr_at(sap_pkg::ADR_TEMP_LIM)) begin
        lim_q[2] <= i_bus.wdata;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      ctrl_q     <= sap_pkg::RST_MON_CTRL;
      rx_mask_q  <= sap_pkg::RST_RX_MASK;
      mon_mask_q <= sap_pkg::RST_ZERO;
      ret_mask_q <= sap_pkg::RST_ZERO;
      irq_mask_q <= '0;
    end else begin
      if (wr_at(sap_pkg::ADR_MON_CTRL)) begin
        ctrl_q <= i_bus.wdata;
      end
      if (wr_at(sap_pkg::ADR_RX_MASK)) begin
        rx_mask_q <= i_bus.wdata;
      end
      if (wr_at(sap_pkg::ADR_MON_MASK)) begin
        mon_mask_q <= i_bus.wdata;
      end
      if (wr_at(sap_pkg::ADR_RET_MASK)) begin
        ret_mask_q <= i_bus.wdata;
      end
      if (wr_at(sap_pkg::ADR_IRQ_MASK)) begin
        irq_mask_q <= i_bus.wdata[sap_pkg::IRQ_W-1:0];
      end
    end
  end

  // The debug enables only store; keeping them zero is up to software.
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      hs_pol_q <= '0;
      lp_pol_q <= sap_pkg::RST_ZERO;
      hs_dbg_q <= '0;
      lp_dbg_q <= '0;
    end else begin
      if (wr_at(sap_pkg::ADR_HS_POL)) begin
        hs_pol_q <= i_bus.wdata[sap_pkg::NLANE-1:0];
      end
      if (wr_at(sap_pkg::ADR_LP_POL)) begin
        lp_pol_q <= i_bus.wdata;
      end
      if (wr_at(sap_pkg::ADR_HS_DBG)) begin
        hs_dbg_q <= i_bus.wdata[sap_pkg::HS_DBG_W-1:0];
      end
      if (wr_at(sap_pkg::ADR_LP_DBG)) begin
        lp_dbg_q <= i_bus.wdata[sap_pkg::HS_DBG_W-1:0];
      end
    end
  end

  // Sticky flags clear by writing one; a new event in the same cycle wins.
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      mon_stat_q <= '0;
    end else begin
      mon_stat_q <= (mon_stat_q & ~({2*NM{stat_clr}}
                    & i_bus.wdata[2*NM-1:0])) | cond;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      irq_stat_q <= '0;
      o_irq      <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~({sap_pkg::IRQ_W{
                    wr_at(sap_pkg::ADR_IRQ_STAT)}}
                    & i_bus.wdata[sap_pkg::IRQ_W-1:0])) | irq_ev;
      o_irq      <= |(irq_stat_q & irq_mask_q);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_rx_alarm  <= '0;
      o_mon_alarm <= '0;
      o_ret_alarm <= '0;
    end else begin
      o_rx_alarm  <= rx_gate;
      o_mon_alarm <= mon_gate;
      o_ret_alarm <= ret_gate;
    end
  end

  // Two-stage synchronisers; only the second stage feeds the inverters.
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      hs_s1_q   <= '0;
      hs_s2_q   <= '0;
      lp_s1_q   <= '0;
      lp_s2_q   <= '0;
      o_hs_lane <= '0;
      o_lp_lane <= '0;
    end else begin
      hs_s1_q   <= i_hs_lane;
      hs_s2_q   <= hs_s1_q;
      lp_s1_q   <= i_lp_lane;
      lp_s2_q   <= lp_s1_q;
      o_hs_lane <= hs_s2_q ^ hs_pol_q;
      o_lp_lane <= lp_s2_q ^ lp_pol_q[sap_pkg::NLANE-1:0];
    end
  end

  // Read data stand for one cycle per cycle of read strobe; unmapped offsets read zero.
  always_comb begin
    rd_d = '0;
    unique case (i_bus.addr)
      sap_pkg::ADR_MON_CTRL: rd_d = ctrl_q;
      sap_pkg::ADR_MON0_LIM: rd_d = lim_q[0];
      sap_pkg::ADR_MON1_LIM: rd_d = lim_q[1];
      sap_pkg::ADR_TEMP_LIM: rd_d = lim_q[2];
      sap_pkg::ADR_RX_MASK:  rd_d = rx_mask_q;
      sap_pkg::ADR_MON_MASK: rd_d = mon_mask_q;
      sap_pkg::ADR_RET_MASK: rd_d = ret_mask_q;
      sap_pkg::ADR_HS_POL:   rd_d = {3'h0, hs_pol_q};
      sap_pkg::ADR_LP_POL:   rd_d = lp_pol_q;
      sap_pkg::ADR_HS_DBG:   rd_d = {1'b0, hs_dbg_q};
      sap_pkg::ADR_LP_DBG:   rd_d = {1'b0, lp_dbg_q};
      sap_pkg::ADR_MON_STAT: rd_d = {2'h0, mon_stat_q};
      sap_pkg::ADR_IRQ_STAT: rd_d = {5'h00, irq_stat_q};
      sap_pkg::ADR_IRQ_MASK: rd_d = {5'h00, irq_mask_q};
      default:               rd_d = '0;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= i_bus.rd ? rd_d : '0;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  AST_MON0_HIGH: assert property (
    ctrl_q[0] && (i_meas.mon0 > lim_q[0][6:4]) |=> mon_stat_q[1])
    else $error("Monitor 0 high flag not set.");

  AST_MON0_LOW: assert property (
    ctrl_q[0] && (i_meas.mon0 < lim_q[0][2:0]) |=> mon_stat_q[0])
    else $error("Monitor 0 low flag not set.");

  AST_MON1_HIGH: assert property (
    ctrl_q[1] && (i_meas.mon1 > lim_q[1][6:4]) && mon_mask_q[3]
    |=> o_mon_alarm[3])
    else $error("Monitor 1 high alarm missing.");

  AST_MON1_LOW: assert property (
    !ctrl_q[1] |=> !o_mon_alarm[2])
    else $error("Monitor 1 low alarm while unselected.");

  AST_TEMP_HIGH: assert property (
    (ctrl_q[3:2] == 2'h3) && (i_meas.temp > lim_q[2][6:4])
    |=> mon_stat_q[5])
    else $error("Temperature high flag not set.");

  AST_TEMP_LOW_QUIET: assert property (
    (ctrl_q[3:2] != 2'h3) |=> !o_mon_alarm[4])
    else $error("Temperature low alarm while disabled.");

  AST_RX_GATE: assert property (
    i_rx_err[5] && rx_mask_q[5] |=> o_rx_alarm[5])
    else $error("Missing frame alarm not passed.");

  AST_RX_BLOCK: assert property (
    !rx_mask_q[4] |=> !o_rx_alarm[4])
    else $error("PHY sync alarm passed while disabled.");

  AST_RX_RESET: assert property (
    $rose(i_reset_n) |-> rx_mask_q[5:0] == 6'h3F)
    else $error("Receive mask reset value wrong.");

  AST_MON_RESET: assert property (
    $rose(i_reset_n) |-> mon_mask_q == 8'h00)
    else $error("Monitor mask not zero after reset.");

  AST_MON_GATE: assert property (
    o_mon_alarm[1] |-> $past(mon_mask_q[1]) && $past(cond[1]))
    else $error("Monitor 0 alarm without cause.");

  AST_RET_GATE: assert property (
    o_ret_alarm[1] |-> $past(i_ret_err[1]) && $past(ret_mask_q[1]))
    else $error("CRC alarm without cause.");

  AST_HS_POL: assert property (
    ##3 o_hs_lane[4] == ($past(i_hs_lane[4], 3) ^ $past(hs_pol_q[4])))
    else $error("High-speed clock lane polarity wrong.");

  AST_LP_POL: assert property (
    ##3 o_lp_lane[0] == ($past(i_lp_lane[0], 3) ^ $past(lp_pol_q[0])))
    else $error("Low-power data lane polarity wrong.");

  AST_SEL_NONE: assert property (
    ctrl_q[1:0] == 2'h0 |=> mon_stat_q[3:0] == $past(mon_stat_q[3:0])
    || $past(stat_clr))
    else $error("Voltage flag set with no monitor selected.");

  AST_STRICT: assert property (
    i_meas.mon0 == lim_q[0][6:4] && !mon_stat_q[1] |=> !mon_stat_q[1])
    else $error("Equal code raised the high flag.");

  AST_IRQ: assert property (
    irq_stat_q[0] && irq_mask_q[0] |=> o_irq)
    else $error("Interrupt not raised.");

  AST_RD_ONE: assert property (
    !i_bus.rd |=> o_rd_data == 8'h00)
    else $error("Read data outside the answer cycle.");

  AST_MON1_HIGH_SET: assert property (
    ctrl_q[1] && (i_meas.mon1 > lim_q[1][6:4]) |=> mon_stat_q[3])
    else $error("Monitor 1 high flag not set.");

  AST_MON1_LOW_SET: assert property (
    ctrl_q[1] && (i_meas.mon1 < lim_q[1][2:0]) |=> mon_stat_q[2])
    else $error("Monitor 1 low flag not set.");

  AST_TEMP_LOW: assert property (
    (ctrl_q[3:2] == 2'h3) && (i_meas.temp < lim_q[2][2:0])
    |=> mon_stat_q[4])
    else $error("Temperature low flag not set.");

  AST_RX_PASS: assert property (
    i_rx_err[4] && rx_mask_q[4] |=> o_rx_alarm[4])
    else $error("PHY sync alarm not passed.");

  AST_RX_LOW: assert property (
    o_rx_alarm[2:0] == ($past(i_rx_err[2:0]) & $past(rx_mask_q[2:0])))
    else $error("Packet alarm does not follow its enable.");

  AST_TEMP_GATE: assert property (
    o_mon_alarm[5] |-> $past(mon_mask_q[5]) && $past(cond[5]))
    else $error("Temperature high alarm without cause.");

  AST_RET_LINK: assert property (
    i_ret_err[0] && ret_mask_q[0] |=> o_ret_alarm[0])
    else $error("Link alarm not passed.");

  AST_HS_DATA: assert property (
    ##3 o_hs_lane[0] == ($past(i_hs_lane[0], 3) ^ $past(hs_pol_q[0])))
    else $error("High-speed data lane polarity wrong.");

  AST_LP_CLK: assert property (
    ##3 o_lp_lane[4] == ($past(i_lp_lane[4], 3) ^ $past(lp_pol_q[4])))
    else $error("Low-power clock lane polarity wrong.");

  AST_SEL_FIRST: assert property (
    ctrl_q[1:0] == 2'h1 && !mon_stat_q[3] |=> !mon_stat_q[3])
    else $error("Monitor 1 flag set while only monitor 0 selected.");

  AST_SET_WINS: assert property (
    stat_clr && i_bus.wdata[0] && cond[0] |=> mon_stat_q[0])
    else $error("Clear request beat a new low flag.");

  COV_MON0_ALARM: cover property (o_mon_alarm[1]);
  COV_TEMP_LOW: cover property (o_mon_alarm[4]);
  COV_IRQ: cover property (o_irq ##1 !o_irq);
  COV_SET_CLEAR: cover property (
    wr_at(sap_pkg::ADR_MON_STAT) && cond[0] && i_bus.wdata[0]);
endmodule
`default_nettype wire

// >>> shared/sap_pkg.sv
// Purpose: Shared constants and carriers for the sensor alarm register bank.
// Assumes: Byte-wide registers at byte offsets on a plain register port.
// Notes:   Reset values are whole-register values built from their fields.
`default_nettype none
package sap_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned LIM_W  = 3;
  localparam int unsigned NMON   = 3;
  localparam int unsigned NLANE  = 5;

  localparam logic [7:0] ADR_MON_CTRL  = 8'h17;
  localparam logic [7:0] ADR_MON0_LIM  = 8'h19;
  localparam logic [7:0] ADR_MON1_LIM  = 8'h1A;
  localparam logic [7:0] ADR_TEMP_LIM  = 8'h1B;
  localparam logic [7:0] ADR_RX_MASK   = 8'h1C;
  localparam logic [7:0] ADR_MON_MASK  = 8'h1D;
  localparam logic [7:0] ADR_RET_MASK  = 8'h1E;
  localparam logic [7:0] ADR_HS_POL    = 8'h20;
  localparam logic [7:0] ADR_LP_POL    = 8'h21;
  localparam logic [7:0] ADR_HS_DBG    = 8'h22;
  localparam logic [7:0] ADR_LP_DBG    = 8'h23;
  localparam logic [7:0] ADR_MON_STAT  = 8'h40;
  localparam logic [7:0] ADR_IRQ_STAT  = 8'h41;
  localparam logic [7:0] ADR_IRQ_MASK  = 8'h42;

  localparam logic [7:0] RST_LIM       = 8'h62;
  localparam logic [7:0] RST_MON_CTRL  = 8'h0C;
  localparam logic [7:0] RST_RX_MASK   = 8'h3F;
  localparam logic [7:0] RST_ZERO      = 8'h00;

  localparam int unsigned LIM_HI_LSB   = 4;
  localparam int unsigned LIM_LO_LSB   = 0;
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_TEN_LSB = 2;
  localparam logic [1:0]  CTRL_TEN_ON  = 2'h3;

  localparam int unsigned RX_MISS_FRAME = 5;
  localparam int unsigned RX_PHY_SYNC   = 4;
  localparam int unsigned RX_PHY_CTRL   = 3;
  localparam int unsigned RX_HDR_ECC2   = 2;
  localparam int unsigned RX_CHECKSUM   = 1;
  localparam int unsigned RX_LENGTH     = 0;
  localparam int unsigned RX_W          = 6;

  localparam int unsigned RET_CRC       = 1;
  localparam int unsigned RET_LINK      = 0;
  localparam int unsigned RET_W         = 2;

  localparam int unsigned IRQ_RX        = 0;
  localparam int unsigned IRQ_MON       = 1;
  localparam int unsigned IRQ_RET       = 2;
  localparam int unsigned IRQ_W         = 3;

  localparam int unsigned LANE_CLK      = 4;
  localparam int unsigned HS_DBG_W      = 7;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sap_bus_t;

  // Monitor 2 is temperature, 1 and 0 are the voltage monitors.
  typedef struct packed {
    logic [LIM_W-1:0] temp;
    logic [LIM_W-1:0] mon1;
    logic [LIM_W-1:0] mon0;
  } sap_meas_t;
endpackage
`default_nettype wire

// >>> verif/sap_alarm_regs_tb_top.sv
// Purpose: Self-checking bench for the alarm and lane polarity registers.
// Assumes: Read data stands only in the cycle after the read strobe.
// Notes:   Random values come from a fixed-seed shift register.
`timescale 1ns/10ps
`default_nettype none
module sap_alarm_regs_tb_top;
  logic               i_ref_clk;
  logic               i_reset_n;
  sap_pkg::sap_bus_t  bus;
  sap_pkg::sap_meas_t meas_req;
  sap_pkg::sap_meas_t meas;
  logic [7:0]         rd_data;
  logic [7:0]         ctl, l0, l1, lt, mm, rm, xm, hp, lp;
  logic [5:0]         rx_req, rx_err, rx_alarm, mon_alarm;
  logic [1:0]         ret_req, ret_err, ret_alarm;
  logic [9:0]         lane_req;
  logic [4:0]         hs_pin, lp_pin, hs_out, lp_out;
  logic               irq;
  logic [15:0]        lfsr;
  int                 fails, n_compared;
  localparam logic [7:0] ADRS [11] = '{sap_pkg::ADR_MON_CTRL,
    sap_pkg::ADR_MON0_LIM, sap_pkg::ADR_MON1_LIM, sap_pkg::ADR_TEMP_LIM,
    sap_pkg::ADR_RX_MASK, sap_pkg::ADR_MON_MASK, sap_pkg::ADR_RET_MASK,
    sap_pkg::ADR_HS_POL, sap_pkg::ADR_LP_POL, sap_pkg::ADR_HS_DBG,
    sap_pkg::ADR_LP_DBG};
  localparam logic [7:0] RSTV [11] = '{8'h0C, 8'h62, 8'h62, 8'h62, 8'h3F,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MSK [11] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'h7F, 8'h7F};

  sap_alarm_regs u_dut (
    .i_ref_clk   (i_ref_clk),
    .i_reset_n   (i_reset_n),
    .i_bus       (bus),
    .o_rd_data   (rd_data),
    .i_meas      (meas),
    .i_rx_err    (rx_err),
    .i_ret_err   (ret_err),
    .i_hs_lane   (hs_pin),
    .i_lp_lane   (lp_pin),
    .o_hs_lane   (hs_out),
    .o_lp_lane   (lp_out),
    .o_rx_alarm  (rx_alarm),
    .o_mon_alarm (mon_alarm),
    .o_ret_alarm (ret_alarm),
    .o_irq       (irq)
  );

  sap_sensor_model u_sensor (
    .i_ref_clk  (i_ref_clk),
    .i_meas_req (meas_req),
    .i_rx_req   (rx_req),
    .i_ret_req  (ret_req),
    .i_lane_req (lane_req),
    .o_meas     (meas),
    .o_rx_err   (rx_err),
    .o_ret_err  (ret_err),
    .o_hs_pin   (hs_pin),
    .o_lp_pin   (lp_pin)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Strict compares; the masks only gate what leaves the block.
  function automatic logic [7:0] exp_mon(input sap_pkg::sap_meas_t m,
    input logic [7:0] c, a, b, t, k);
    logic [5:0] r;
    r[0] = c[0] && (m.mon0 < a[2:0]);
    r[1] = c[0] && (m.mon0 > a[6:4]);
    r[2] = c[1] && (m.mon1 < b[2:0]);
    r[3] = c[1] && (m.mon1 > b[6:4]);
    r[4] = (c[3:2] == 2'h3) && (m.temp < t[2:0]);
    r[5] = (c[3:2] == 2'h3) && (m.temp > t[6:4]);
    return {2'h0, r & k[5:0]};
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen, e);
    n_compared++;
    if (seen !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge i_ref_clk) bus <= {a, d, 2'h2};
    @(posedge i_ref_clk) bus.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, e);
    @(posedge i_ref_clk) bus <= {a, 8'h00, 2'h1};
    @(posedge i_ref_clk) bus.rd <= 1'b0;
    #1 chk("rd_data", rd_data, e);
  endtask

  task automatic rnd(output logic [7:0] v);
    lfsr = lfsr_next(lfsr);
    v = lfsr[7:0];
  endtask

  task automatic wrap_up();
    $display("fails=%0d n_compared=%0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    fails++;
    wrap_up();
  end

  initial begin
    lfsr = 16'h975F;
    fails = 0;
    n_compared = 0;
    i_reset_n = 1'b0;
    bus = '0;
    meas_req = '0;
    rx_req = '0;
    ret_req = '0;
    lane_req = '0;
    repeat (4) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    for (int i = 0; i < 11; i++) rd_chk(ADRS[i], RSTV[i]);
    rd_chk(8'h30, 8'h00);
    for (int i = 0; i < 11; i++) begin
      rnd(xm);
      wr(ADRS[i], xm);
      rd_chk(ADRS[i], xm & MSK[i]);
    end
    wr(8'h30, 8'hFF);
    rd_chk(8'h30, 8'h00);
    wr(sap_pkg::ADR_HS_DBG, 8'h00);
    // Random mixes of selections, limits, masks and levels.
    for (int n = 0; n < 48; n++) begin
      rnd(ctl); rnd(l0); rnd(l1); rnd(lt); rnd(mm); rnd(rm); rnd(xm);
      rnd(hp); rnd(lp);
      if (n < 4) ctl[3:0] = {2'h3, n[1:0]};
      wr(sap_pkg::ADR_MON_CTRL, ctl);
      wr(sap_pkg::ADR_MON0_LIM, l0);
      wr(sap_pkg::ADR_MON1_LIM, l1);
      wr(sap_pkg::ADR_TEMP_LIM, lt);
      wr(sap_pkg::ADR_MON_MASK, mm);
      wr(sap_pkg::ADR_RX_MASK, rm);
      wr(sap_pkg::ADR_RET_MASK, xm);
      wr(sap_pkg::ADR_HS_POL, hp);
      wr(sap_pkg::ADR_LP_POL, lp);
      lfsr = lfsr_next(lfsr);
      @(posedge i_ref_clk);
      meas_req <= lfsr[8:0];
      rx_req <= lfsr[14:9];
      ret_req <= {lfsr[15], lfsr[0]};
      lane_req <= {lp[4:0] ^ lfsr[9:5], lfsr[4:0]};
      repeat (6) @(posedge i_ref_clk);
      #1;
      chk("mon_alarm", {2'h0, mon_alarm},
          exp_mon(meas, ctl, l0, l1, lt, mm));
      chk("rx_alarm", {2'h0, rx_alarm}, {2'h0, rx_req & rm[5:0]});
      chk("ret_alarm", {6'h0, ret_alarm}, {6'h0, ret_req & xm[1:0]});
      chk("hs_lane", {3'h0, hs_out}, {3'h0, lane_req[4:0] ^ hp[4:0]});
      chk("lp_lane", {3'h0, lp_out}, {3'h0, lane_req[9:5] ^ lp[4:0]});
    end
    // Sticky status, masked interrupt and write-one-to-clear.
    wr(sap_pkg::ADR_MON_CTRL, 8'h01);
    wr(sap_pkg::ADR_MON0_LIM, 8'h62);
    wr(sap_pkg::ADR_MON_MASK, 8'h02);
    wr(sap_pkg::ADR_RX_MASK, 8'h00);
    wr(sap_pkg::ADR_RET_MASK, 8'h00);
    wr(sap_pkg::ADR_IRQ_MASK, 8'h02);
    @(posedge i_ref_clk) meas_req <= 9'h004;
    repeat (4) @(posedge i_ref_clk);
    wr(sap_pkg::ADR_MON_STAT, 8'hFF);
    wr(sap_pkg::ADR_IRQ_STAT, 8'hFF);
    repeat (3) @(posedge i_ref_clk);
    #1 chk("irq", {7'h0, irq}, 8'h00);
    @(posedge i_ref_clk) meas_req <= 9'h007;
    repeat (4) @(posedge i_ref_clk);
    #1 chk("irq", {7'h0, irq}, 8'h01);
    @(posedge i_ref_clk) meas_req <= 9'h000;
    repeat (4) @(posedge i_ref_clk);
    #1 chk("mon_alarm", {2'h0, mon_alarm}, 8'h00);
    rd_chk(sap_pkg::ADR_MON_STAT, 8'h03);
    rd_chk(sap_pkg::ADR_IRQ_STAT, 8'h02);
    wr(sap_pkg::ADR_IRQ_STAT, 8'h02);
    repeat (3) @(posedge i_ref_clk);
    #1 chk("irq", {7'h0, irq}, 8'h00);
    // Bit 0 is cleared while its low condition still stands, so it must stay.
    wr(sap_pkg::ADR_MON_STAT, 8'h03);
    rd_chk(sap_pkg::ADR_MON_STAT, 8'h01);
    wrap_up();
  end
endmodule
`default_nettype wire

// >>> verif/sap_sensor_model.sv
// Purpose: Sensor side model driving measurements, error levels and lanes.
// Assumes: Every level is launched just after a rising clock edge.
// Notes:   The bench asks for values and the model drives them one edge on.
`timescale 1ns/10ps
`default_nettype none
module sap_sensor_model (
  input  wire logic                      i_ref_clk,
  input  wire sap_pkg::sap_meas_t        i_meas_req,
  input  wire logic [sap_pkg::RX_W-1:0]  i_rx_req,
  input  wire logic [sap_pkg::RET_W-1:0] i_ret_req,
  input  wire logic [9:0]                i_lane_req,
  output var  sap_pkg::sap_meas_t        o_meas,
  output var  logic [sap_pkg::RX_W-1:0]  o_rx_err,
  output var  logic [sap_pkg::RET_W-1:0] o_ret_err,
  output var  logic [4:0]                o_hs_pin,
  output var  logic [4:0]                o_lp_pin
);
  // Levels are registered so they never move on the sampling edge itself.
  always_ff @(posedge i_ref_clk) begin
    o_meas    <= i_meas_req;
    o_rx_err  <= i_rx_req;
    o_ret_err <= i_ret_req;
    o_hs_pin  <= i_lane_req[4:0];
    o_lp_pin  <= i_lane_req[9:5];
  end
endmodule
`default_nettype wire
